/* src/pan_autoneg.sv */
// negotiation control of a 10/100 transceiver with its management registers
//
// Notes on behaviour
// - strap sampled after reset loads advertised bits 8:5, low gives half duplex only
// - advertisement writes override the strap-chosen bits at any time after the strap load
// - while detecting, the advertisement word is sent as link pulse bursts
// - common mode priority: 100 full, 100 half, 10 full, 10 half
// - forced mode uses speed and duplex bits, ignored while negotiation enabled
// - link summary register reports resolved speed once link is up
// - ability bits read fixed as supported, the T4 bit reads clear
// - basic status shows completion, remote fault, link and preamble suppression
// - advertisement defaults to all abilities, cleared bits are not offered
// - partner register captures the base page word received while detecting, later pages are not captured
// - parallel detect loads partner register with 0081 or 0021
// - expansion shows detect fault, both next page supports, page, partner able
// - both receivers feed link status, a lone good link picks that technology
// - after parallel detect completion the partner-able bit reads zero
// - detect fault is set when more than one good link is seen
// - restart bit starts a new negotiation whenever it is written together with the enable bit set
// - a negotiated link that fails resumes negotiation
// - renegotiation silences the line for the break timer, then bursts resume
// - negotiation and parallel detect finish within a few seconds
`timescale 1ns/1ps
`default_nettype none
module pan_autoneg #(
  parameter int unsigned BREAK_CYCLES = pan_pkg::BREAK_CYC,
  parameter int unsigned LFI_CYCLES   = pan_pkg::LFI_CYC,
  parameter int unsigned CW           = 24,
  parameter logic        LOCAL_NP     = 1'b1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  // strap and receivers
  input  wire logic             negotiation_strap,
  input  wire pan_pkg::pan_rx_t rx_link,
  input  wire logic             lp_word_valid,
  input  wire logic [15:0]      lp_word,
  // line control and result
  output var  logic             flp_send,
  output var  logic [15:0]      flp_word,
  output var  logic             tx_halt,
  output var  pan_pkg::pan_mode_t mode,
  output var  logic             link_up,
  output var  logic             an_complete
);
  import pan_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parameter check
  if (BREAK_CYCLES < 2 || LFI_CYCLES < 2 || CW > 31 ||
      BREAK_CYCLES >= (32'h1 << CW) || LFI_CYCLES >= (32'h1 << CW)) begin : g_bad
    $error("pan_autoneg: counts do not fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  pan_state_t  st_ff;
  pan_state_t  nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [2:0]  strap_cnt_ff;
  logic        strap_done_ff;
  logic [15:0] basic_control_reg_ff;
  logic [15:0] advert_ability_reg_ff;
  logic [15:0] partner_ability_reg_ff;
  logic        pdf_ff;
  logic        page_ff;
  logic        lpan_ff;
  logic        cmpl_ff;
  logic [2:0]  sync_q;
  logic        strap_s;
  pan_rx_t     rx_s;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs
  pan_sync3 #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({negotiation_strap, rx_link}),
    .q       (sync_q)
  );
  assign strap_s = sync_q[2];
  assign rx_s    = sync_q[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire       acc      = psel & penable;
  wire       wr_go    = acc & pwrite & pready;
  wire       rd_go    = acc & ~pwrite & pready;
  wire [5:0] idx      = paddr[7:2];
  wire       aligned  = paddr[1:0] == 2'b00;
  wire       hit_ctrl = aligned & (idx == IDX_CTRL);
  wire       hit_stat = aligned & (idx == IDX_STAT);
  wire       hit_adv  = aligned & (idx == IDX_ADV);
  wire       hit_lp   = aligned & (idx == IDX_LP);
  wire       hit_exp  = aligned & (idx == IDX_EXP);
  wire       hit_sum  = aligned & (idx == IDX_SUM);
  wire       hit_any  = hit_ctrl | hit_stat | hit_adv | hit_lp | hit_exp | hit_sum;
  wire       wr_ctrl  = wr_go & hit_ctrl;
  wire       wr_adv   = wr_go & hit_adv;
  wire       rd_exp   = rd_go & hit_exp;

  ////////////////////////////////////////////////////////////////////////////
  // negotiation requests
  wire an_en     = basic_control_reg_ff[C_ANEN];
  wire an_en_new = wr_ctrl ? pwdata[C_ANEN] : an_en;
  wire an_rise   = wr_ctrl & pwdata[C_ANEN] & ~an_en;
  wire restart   = wr_ctrl & pwdata[C_ANEN] & pwdata[C_RESTART];
  wire reneg     = an_rise | restart;

  ////////////////////////////////////////////////////////////////////////////
  // resolution
  wire [3:0]  common   = advert_ability_reg_ff[A_HI:A_LO] &
                         partner_ability_reg_ff[A_HI:A_LO];
  wire        have_cm  = common != 4'h0;
  pan_mode_t  forced_m;
  assign forced_m = {basic_control_reg_ff[C_SPEED],
                     basic_control_reg_ff[C_DUPLEX]};
  wire pan_mode_t res_m    = an_en ? pan_resolve(common) : forced_m;
  wire        res_link = (res_m.speed100 ? rx_s.link100 : rx_s.link10) &
                         (have_cm | ~an_en);
  wire        pd_one   = rx_s.link10 ^ rx_s.link100;
  wire        pd_many  = rx_s.link10 & rx_s.link100;
  wire        detect   = (st_ff == ST_DETECT) & strap_done_ff;
  wire        got_word = detect & lp_word_valid;
  wire        got_pd   = detect & ~lp_word_valid & pd_one;
  wire        cnt_zero = cnt_ff == '0;
  wire [15:0] pd_word  = rx_s.link100 ? PD_LP_100 : PD_LP_10;

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb begin
    nxt_st = st_ff;
    if (!an_en_new) begin
      nxt_st = ST_OFF;
    end else if (reneg) begin
      nxt_st = ST_BREAK;
    end else begin
      unique case (st_ff)
        ST_OFF: begin
          nxt_st = ST_OFF;
        end
        ST_BREAK: begin
          if (cnt_zero) nxt_st = ST_DETECT;
        end
        ST_DETECT: begin
          if (got_word || got_pd) nxt_st = ST_WAIT;
        end
        ST_WAIT: begin
          if (res_link) nxt_st = ST_GOOD;
          else if (cnt_zero) nxt_st = ST_DETECT;
        end
        ST_GOOD: begin
          if (!res_link) nxt_st = ST_DETECT;
        end
        default: begin
          nxt_st = ST_DETECT;
        end
      endcase
    end
  end

  assign nxt_cnt = (nxt_st != st_ff) ?
                   ((nxt_st == ST_BREAK) ? CW'(BREAK_CYCLES - 1) : CW'(LFI_CYCLES - 1)) :
                   (cnt_zero ? cnt_ff : cnt_ff - CW'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff  <= ST_DETECT;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_ff  <= 3'h0;
      strap_done_ff <= 1'b0;
    end else begin
      if (!strap_done_ff) strap_cnt_ff <= strap_cnt_ff + 3'h1;
      if (strap_cnt_ff == STRAP_WAIT) strap_done_ff <= 1'b1;
    end
  end
  wire strap_load = ~strap_done_ff & (strap_cnt_ff == STRAP_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // control and advertisement registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_control_reg_ff  <= CTRL_RST;
      advert_ability_reg_ff <= ADV_RST;
    end else begin
      if (wr_ctrl) basic_control_reg_ff <= pwdata[15:0] & CTRL_MASK;
      if (strap_load) begin
        advert_ability_reg_ff[A_HI:A_LO] <= strap_s ? ADV_HI : ADV_LO;
      end else if (wr_adv) begin
        advert_ability_reg_ff <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // partner capture and expansion flags, a set wins over clear on read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_ability_reg_ff <= 16'h0000;
      pdf_ff  <= 1'b0;
      page_ff <= 1'b0;
      lpan_ff <= 1'b0;
    end else begin
      if (got_word) partner_ability_reg_ff <= lp_word;
      else if (got_pd) partner_ability_reg_ff <= pd_word;
      if (got_word) lpan_ff <= 1'b1;
      else if (got_pd) lpan_ff <= 1'b0;
      pdf_ff  <= (detect & ~lp_word_valid & pd_many) | (pdf_ff & ~rd_exp);
      page_ff <= got_word | (page_ff & ~rd_exp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line and result outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flp_send    <= 1'b0;
      flp_word    <= ADV_RST;
      tx_halt     <= 1'b0;
      mode        <= '0;
      link_up     <= 1'b0;
      an_complete <= 1'b0;
      cmpl_ff     <= 1'b0;
    end else begin
      flp_send    <= (nxt_st == ST_DETECT) & (strap_done_ff | strap_load);
      flp_word    <= advert_ability_reg_ff;
      tx_halt     <= nxt_st == ST_BREAK;
      mode        <= res_m;
      link_up     <= (nxt_st == ST_GOOD) | ((nxt_st == ST_OFF) & res_link);
      an_complete <= nxt_st == ST_GOOD;
      cmpl_ff     <= nxt_st == ST_GOOD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [15:0] stat_w = STAT_FIX | (16'(cmpl_ff) << S_CMPL) |
                       (16'(partner_ability_reg_ff[LP_RF]) << S_RF) |
                       (16'(link_up) << S_LINK);
  wire [15:0] exp_w  = (16'(pdf_ff) << E_PDF) |
                       (16'(partner_ability_reg_ff[LP_NP]) << E_LPNP) |
                       (16'(LOCAL_NP) << E_NP) |
                       (16'(page_ff) << E_PAGE) |
                       (16'(lpan_ff) << E_LPAN);
  wire [15:0] sum_w  = (16'(link_up) << M_LINK) |
                       (16'(link_up & ~mode.speed100) << M_SPD10) |
                       (16'(link_up & mode.full_dup) << M_DUP) |
                       (16'(cmpl_ff) << M_CMPL);
  wire [15:0] rd16   = hit_ctrl ? basic_control_reg_ff :
                       hit_stat ? stat_w :
                       hit_adv  ? advert_ability_reg_ff :
                       hit_lp   ? partner_ability_reg_ff :
                       hit_exp  ? exp_w :
                       hit_sum  ? sum_w : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      if (acc && !pready) begin
        prdata  <= {16'h0000, rd16};
        pslverr <= ~hit_any;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_reneg;
    reneg && an_en_new;
  endsequence

  sequence s_quiet;
    (tx_halt && !flp_send)[*4];
  endsequence

  property p_strap_adv;
    $rose(strap_done_ff) |->
      advert_ability_reg_ff[A_HI:A_LO] == (strap_s ? ADV_HI : ADV_LO);
  endproperty
  a_strap_adv: assert property (p_strap_adv)
    else $error("advertisement not loaded from strap");

  property p_prio;
    (st_ff == ST_GOOD && an_en && common[3] && $stable(common)) |->
      mode.speed100 && mode.full_dup;
  endproperty
  a_prio: assert property (p_prio)
    else $error("100 full duplex not chosen first");

  property p_forced;
    (!an_en && $stable(basic_control_reg_ff))[*2] |->
      mode.speed100 == basic_control_reg_ff[C_SPEED] &&
      mode.full_dup == basic_control_reg_ff[C_DUPLEX];
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced mode not taken from control bits");

  property p_break;
    s_reneg |=> s_quiet;
  endproperty
  a_break: assert property (p_break)
    else $error("line not silenced after renegotiation");

  property p_lp_cap;
    got_word |=> partner_ability_reg_ff == $past(lp_word);
  endproperty
  a_lp_cap: assert property (p_lp_cap)
    else $error("partner word not captured");

  property p_pd_word;
    got_pd |=> partner_ability_reg_ff[4:0] == SEL_8023 && !lpan_ff;
  endproperty
  a_pd_word: assert property (p_pd_word)
    else $error("parallel detect word wrong");

  property p_pd_fault;
    (detect && !lp_word_valid && pd_many) |=> pdf_ff;
  endproperty
  a_pd_fault: assert property (p_pd_fault)
    else $error("detect fault not flagged");

  property p_relink;
    (st_ff == ST_GOOD && !res_link && an_en && !wr_ctrl) |=> st_ff == ST_DETECT && flp_send;
  endproperty
  a_relink: assert property (p_relink)
    else $error("negotiation not resumed after link loss");

  property p_apb;
    (acc && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb answer not one cycle");

endmodule : pan_autoneg
`default_nettype wire

/* src/pan_pkg.sv */
// constants, field layouts and types of the negotiation control block
package pan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_KHZ    = 10000;
  localparam int unsigned BREAK_MS   = 1500;
  localparam int unsigned LFI_MS     = 750;
  localparam int unsigned BREAK_CYC  = BREAK_MS * CLK_KHZ;
  localparam int unsigned LFI_CYC    = LFI_MS * CLK_KHZ;
  localparam logic [2:0]  STRAP_WAIT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_ADV  = 6'h04;
  localparam logic [5:0] IDX_LP   = 6'h05;
  localparam logic [5:0] IDX_EXP  = 6'h06;
  localparam logic [5:0] IDX_SUM  = 6'h10;

  ////////////////////////////////////////////////////////////////////////////
  // basic control fields
  localparam int unsigned C_SPEED   = 13;
  localparam int unsigned C_ANEN    = 12;
  localparam int unsigned C_RESTART = 9;
  localparam int unsigned C_DUPLEX  = 8;
  localparam logic [15:0] CTRL_MASK = 16'h3100;
  localparam logic [15:0] CTRL_RST  = 16'h3000;

  // ability fields of advertised and partner words
  localparam int unsigned A_LO      = 5;
  localparam int unsigned A_HI      = 8;
  localparam int unsigned LP_RF     = 13;
  localparam int unsigned LP_NP     = 15;
  localparam logic [3:0]  ADV_LO    = 4'h5;
  localparam logic [3:0]  ADV_HI    = 4'hf;
  localparam logic [15:0] ADV_RST   = 16'h01e1;
  localparam logic [15:0] PD_LP_100 = 16'h0081;
  localparam logic [15:0] PD_LP_10  = 16'h0021;
  localparam logic [4:0]  SEL_8023  = 5'h01;

  // basic status fields
  localparam logic [15:0] STAT_FIX  = 16'h7849;
  localparam int unsigned S_CMPL    = 5;
  localparam int unsigned S_RF      = 4;
  localparam int unsigned S_LINK    = 2;

  // expansion fields
  localparam int unsigned E_PDF     = 4;
  localparam int unsigned E_LPNP    = 3;
  localparam int unsigned E_NP      = 2;
  localparam int unsigned E_PAGE    = 1;
  localparam int unsigned E_LPAN    = 0;

  // link summary fields
  localparam int unsigned M_LINK    = 0;
  localparam int unsigned M_SPD10   = 1;
  localparam int unsigned M_DUP     = 2;
  localparam int unsigned M_CMPL    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_BREAK  = 3'b000,
    ST_DETECT = 3'b001,
    ST_WAIT   = 3'b011,
    ST_GOOD   = 3'b010,
    ST_OFF    = 3'b110
  } pan_state_t;

  typedef struct packed {
    logic speed100;
    logic full_dup;
  } pan_mode_t;

  typedef struct packed {
    logic link100;
    logic link10;
  } pan_rx_t;

  // highest common mode, abilities ordered 100fd,100hd,10fd,10hd
  function automatic pan_mode_t pan_resolve(input logic [3:0] c);
    pan_mode_t m;
    m.speed100 = c[3] | c[2];
    m.full_dup = c[3] | (~c[2] & c[1]);
    return m;
  endfunction : pan_resolve

endpackage : pan_pkg

/* src/pan_sync3.sv */
// three-stage synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pan_sync3 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q     <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q     <= (s2_ff & s3_ff) | (q & (s2_ff | s3_ff));
    end
  end

endmodule : pan_sync3
`default_nettype wire

/* verification/pan_partner.sv */
// behavioural link partner driving the receiver side of the negotiation block
`timescale 1ns/1ps
`default_nettype none
module pan_partner
  import pan_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // line from the block
  input  wire logic             flp_send,
  input  wire logic             tx_halt,
  // behaviour chosen by the bench
  input  wire logic             negotiates,
  input  wire logic [15:0]      ability,
  input  wire logic [1:0]       links,
  // towards the block
  output var  pan_pkg::pan_rx_t rx_link,
  output var  logic             lp_word_valid,
  output var  logic [15:0]      lp_word
);
  logic [3:0]  cnt_ff;
  logic        linked_ff;
  logic        valid_ff;
  logic [15:0] junk_ff;

  ////////////////////////////////////////////////////////////////////////////
  // one code word some cycles after bursts start, link signals follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff    <= 4'h0;
      linked_ff <= 1'b0;
      valid_ff  <= 1'b0;
      junk_ff   <= 16'h0;
    end else begin
      valid_ff <= 1'b0;
      junk_ff  <= junk_ff + 16'h1;
      if (tx_halt) begin
        cnt_ff    <= 4'h0;
        linked_ff <= 1'b0;
      end else if (negotiates && (flp_send || cnt_ff != 4'h0) && cnt_ff != 4'hf) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff == 4'h3) valid_ff <= 1'b1;
        if (cnt_ff == 4'h6) linked_ff <= 1'b1;
      end
    end
  end

  // word lines show a moving pattern outside the valid pulse
  assign lp_word_valid = valid_ff;
  assign lp_word       = valid_ff ? ability : junk_ff;
  assign rx_link       = links & {2{linked_ff | ~negotiates}};
endmodule : pan_partner
`default_nettype wire

/* verification/test_pan_autoneg.sv */
// register-level bench of the negotiation block against the partner model
`timescale 1ns/1ps
`default_nettype none
module test_pan_autoneg;
  import pan_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic flp_send, tx_halt, link_up, an_complete, lpv, neg;
  logic [15:0] flp_word, lpw, ability, q;
  logic [1:0] links;
  pan_rx_t rx;
  pan_mode_t mode;
  int errors, samples_checked;
  logic [15:0] words [4] = '{16'h0021, 16'h0041, 16'h0081, 16'ha101};

  pan_autoneg #(.BREAK_CYCLES(20), .LFI_CYCLES(40)) i_pan_autoneg (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .negotiation_strap(strap), .rx_link(rx), .lp_word_valid(lpv), .lp_word(lpw),
    .flp_send(flp_send), .flp_word(flp_word), .tx_halt(tx_halt), .mode(mode),
    .link_up(link_up), .an_complete(an_complete));
  pan_partner i_pan_partner (.pclk(pclk), .presetn(presetn), .flp_send(flp_send),
    .tx_halt(tx_halt), .negotiates(neg), .ability(ability), .links(links), .rx_link(rx),
    .lp_word_valid(lpv), .lp_word(lpw));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] d);
    int n;
    // one edge passes between transfers, and setup always starts on a rising edge
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata[15:0];
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      conclude();
    end
  endtask : apb

  task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0);
    chk(q, exp, "register read");
  endtask : rd

  // 0: completion, 1: bursts running, 2: completion gone
  task automatic wait_for(input int which);
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge pclk);
      if ((which == 0 && an_complete === 1'b1) || (which == 1 && flp_send === 1'b1)
          || (which == 2 && an_complete === 1'b0)) break;
    end
    if (n >= 400) begin
      errors++;
      conclude();
    end
    @(posedge pclk);
  endtask : wait_for

  task automatic renegotiate(input logic n, input logic [15:0] w, input logic [1:0] l);
    neg <= n; ability <= w; links <= l;
    apb(1'b1, IDX_CTRL, 16'h1200);
    repeat (2) @(negedge pclk);
    chk({14'h0, tx_halt, flp_send}, 16'h0002, "line silence");
    wait_for(1);
  endtask : renegotiate

  task automatic do_reset(input logic s);
    presetn <= 1'b0; strap <= s;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; strap = 1'b1; neg = 1'b0; ability = 16'h0; links = 2'b00;
    errors = 0; samples_checked = 0;
    do_reset(1'b1);
    rd(IDX_ADV, ADV_RST);
    chk(flp_word, ADV_RST, "burst word");
    rd(IDX_CTRL, CTRL_RST);
    rd(IDX_STAT, STAT_FIX);
    apb(1'b0, 6'h02, 16'h0);
    chk({pslverr, q[14:0]}, 16'h8000, "unmapped read");
    do_reset(1'b0);
    rd(IDX_ADV, 16'h00a1);
    $display("test reset done");
    apb(1'b1, IDX_ADV, ADV_RST);
    for (int i = 0; i < 4; i++) begin
      renegotiate(1'b1, words[i], (i > 1) ? 2'b10 : 2'b01);
      wait_for(0);
      chk({14'h0, mode}, 16'(i), "resolved mode");
      rd(IDX_LP, words[i]);
    end
    rd(IDX_SUM, 16'h0015);
    rd(IDX_STAT, STAT_FIX | 16'h0034);
    rd(IDX_EXP, 16'h000f);
    rd(IDX_EXP, 16'h000d);
    links <= 2'b00;
    wait_for(2);
    wait_for(1);
    $display("test priority done");
    apb(1'b1, IDX_ADV, 16'h0021);
    renegotiate(1'b1, ADV_RST, 2'b01);
    wait_for(0);
    chk({14'h0, mode}, 16'h0000, "restricted mode");
    chk(flp_word, 16'h0021, "restricted burst word");
    rd(IDX_SUM, 16'h0013);
    apb(1'b1, IDX_ADV, ADV_RST);
    $display("test restrict done");
    renegotiate(1'b0, 16'h0, 2'b10);
    wait_for(0);
    rd(IDX_LP, PD_LP_100);
    rd(IDX_EXP, 16'h0006);
    renegotiate(1'b0, 16'h0, 2'b01);
    wait_for(0);
    rd(IDX_LP, PD_LP_10);
    renegotiate(1'b0, 16'h0, 2'b11);
    repeat (12) @(posedge pclk);
    apb(1'b0, IDX_EXP, 16'h0);
    chk({q[4], 14'h0, an_complete}, 16'h8000, "detect fault");
    $display("test parallel done");
    apb(1'b1, IDX_CTRL, 16'h2100);
    repeat (6) @(negedge pclk);
    chk({13'h0, link_up, mode}, 16'h0007, "forced 100 full");
    apb(1'b1, IDX_CTRL, 16'h0200);
    repeat (4) @(negedge pclk);
    chk({14'h0, mode}, 16'h0000, "forced 10 half");
    chk({15'h0, tx_halt}, 16'h0000, "restart while forced");
    @(posedge pclk);
    neg <= 1'b1; ability <= ADV_RST; links <= 2'b10;
    apb(1'b1, IDX_CTRL, 16'h1000);
    wait_for(1);
    wait_for(0);
    chk({14'h0, mode}, 16'h0003, "bits ignored");
    rd(IDX_CTRL, 16'h1000);
    $display("test forced done");
    conclude();
  end
endmodule : test_pan_autoneg
`default_nettype wire
